// ### hw/ocs_pkg.sv
package ocs_pkg;

	// ****************************************
	// output counts
	// ****************************************
	localparam int PCI_BUS_COUNT  = 7;
	localparam int PCI_FREE_COUNT = 3;
	localparam int CPU_PAIR_COUNT = 3;

	// ****************************************
	// timing
	// ****************************************
	localparam int REF_CLK_HZ       = 20000000;
	localparam int STOP_SETUP_NS    = 10;
	localparam int CPU_SAMPLE_EDGES = 2;
	localparam logic [1:0] CPU_SAMPLE_LAST = 2'h1;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [6:0] PCI_BUS_RESET  = 7'h00;
	localparam logic [2:0] PCI_FREE_RESET = 3'h0;
	localparam logic [2:0] CPU_RESET      = 3'h0;
	localparam logic [2:0] SYNC_RESET     = 3'h7;

	// per-pair cpu drive state
	typedef struct packed {
		logic cpu_pair_true_leg;
		logic cpu_pair_complement_leg;
		logic complement_oe_n;
		logic true_boost;
	} ocs_cpu_pin_s;

	typedef enum logic [2:0] {
		CPU_RUN  = 3'b001,
		CPU_SAMP = 3'b010,
		CPU_PARK = 3'b100
	} ocs_cpu_state_e;

endpackage

// ### hw/ocs_stop_ctrl.sv
`timescale 1ns/100ps
module ocs_stop_ctrl
	import ocs_pkg::*;
(
	// clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	// stop requests from the chipset
	input  wire logic                      pci_stop_request_n,
	input  wire logic                      cpu_stop_request_n,
	input  wire logic                      power_down_request_n,
	// configuration
	input  wire logic [PCI_FREE_COUNT-1:0] free_stoppable,
	input  wire logic [CPU_PAIR_COUNT-1:0] cpu_stoppable,
	input  wire logic                      drive_current_multiplier_select,
	// generated clocks
	output logic [PCI_BUS_COUNT-1:0]       pci_bus_clock_out,
	output logic [PCI_FREE_COUNT-1:0]      free_running_pci_clock_out,
	output logic [CPU_PAIR_COUNT-1:0]      cpu_pair_true_leg,
	output logic [CPU_PAIR_COUNT-1:0]      cpu_pair_complement_leg,
	output logic [CPU_PAIR_COUNT-1:0]      cpu_complement_oe_n,
	output logic [CPU_PAIR_COUNT-1:0]      cpu_true_boost,
	output logic                           cpu_stopped
);

	// ****************************************
	// synchronisers
	// ****************************************
	// third stage only agrees once the second settles
	logic [2:0] pci_sync;
	logic [2:0] cpu_sync;
	logic [2:0] pd_sync;
	logic       pci_stop;
	logic       cpu_stop_req;
	logic       pd_stop;

	// stage one may go metastable, so only the shift reads it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pci_sync <= SYNC_RESET;
			cpu_sync <= SYNC_RESET;
			pd_sync  <= SYNC_RESET;
		end else begin
			pci_sync <= {pci_sync[1:0], pci_stop_request_n};
			cpu_sync <= {cpu_sync[1:0], cpu_stop_request_n};
			pd_sync  <= {pd_sync[1:0], power_down_request_n};
		end
	end

	// ****************************************
	// request filter
	// ****************************************
	// a level counts once stages two and three agree,
	// so a pin glitch shorter than two edges never stops a clock
	function automatic logic settle(input logic [2:0] stages, input logic held);
		logic level;
		level = held;
		if (stages[1] == stages[2])
			level = ~stages[2];
		return level;
	endfunction

	wire next_pci_stop     = settle(pci_sync, pci_stop);
	wire next_cpu_stop_req = settle(cpu_sync, cpu_stop_req);
	wire next_pd_stop      = settle(pd_sync, pd_stop);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pci_stop     <= 1'b0;
			cpu_stop_req <= 1'b0;
			pd_stop      <= 1'b0;
		end else begin
			pci_stop     <= next_pci_stop;
			cpu_stop_req <= next_cpu_stop_req;
			pd_stop      <= next_pd_stop;
		end
	end

	// ****************************************
	// output clock phase
	// ****************************************
	// outputs toggle each ref_clk edge, so a falling output edge is phase going low
	// limitation: outputs run at half of ref_clk; a faster
	// output clock would need its own domain and the same filter
	logic phase;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			phase <= 1'b0;
		else
			phase <= ~phase;
	end
	wire falling_next = phase;

	// ****************************************
	// pci gating
	// ****************************************
	// gate latched only when output is about to fall, no runt high pulse
	logic pci_gated;
	wire  pci_want       = pci_stop | pd_stop;
	// a stop taken while the output is low waits for the next fall
	wire  next_pci_gated = pci_want & (falling_next | pci_gated);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			pci_gated <= 1'b0;
		else
			pci_gated <= next_pci_gated;
	end

	// release only starts a high phase, so the first pulse is full length
	wire next_run_pci = ~phase & ~next_pci_gated;

	// ****************************************
	// free-running pci selection
	// ****************************************
	// non-stoppable free outputs keep running through a pci stop
	wire [PCI_FREE_COUNT-1:0] free_gate = free_stoppable | {PCI_FREE_COUNT{pd_stop}};
	wire [PCI_FREE_COUNT-1:0] free_run  = {PCI_FREE_COUNT{~phase}} & ~free_gate;
	wire [PCI_FREE_COUNT-1:0] free_held = {PCI_FREE_COUNT{next_run_pci}} & free_gate;

	// ****************************************
	// pci output registers
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pci_bus_clock_out          <= PCI_BUS_RESET;
			free_running_pci_clock_out <= PCI_FREE_RESET;
		end else begin
			pci_bus_clock_out          <= {PCI_BUS_COUNT{next_run_pci}};
			free_running_pci_clock_out <= free_run | free_held;
		end
	end

	// ****************************************
	// cpu stop sequencer
	// ****************************************
	ocs_cpu_state_e state;
	ocs_cpu_state_e next_state;
	logic [1:0]     samp_cnt;
	logic [CPU_PAIR_COUNT-1:0] parked;

	wire       cpu_want      = cpu_stop_req | pd_stop;
	wire       samp_done     = samp_cnt == CPU_SAMPLE_LAST;
	// counts the two sampling edges; cleared whenever the state is not CPU_SAMP
	wire [1:0] next_samp_cnt = (state == CPU_SAMP) ? samp_cnt + 2'h1 : 2'h0;

	always_comb begin
		next_state = state;
		unique case (state)
			CPU_RUN:  if (cpu_want) next_state = CPU_SAMP;
			CPU_SAMP: if (!cpu_want) next_state = CPU_RUN;
				else if (samp_done) next_state = CPU_PARK;
			CPU_PARK: if (!cpu_want) next_state = CPU_RUN;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state    <= CPU_RUN;
			samp_cnt <= 2'h0;
		end else begin
			state    <= next_state;
			samp_cnt <= next_samp_cnt;
		end
	end

	// ****************************************
	// cpu pair parking
	// ****************************************
	// a pair parks only at its next rising transition, so true ends high whole
	wire park_edge = ~phase;
	wire [CPU_PAIR_COUNT-1:0] park_sel = cpu_stoppable | {CPU_PAIR_COUNT{pd_stop}};
	wire [CPU_PAIR_COUNT-1:0] next_parked = (state == CPU_PARK)
		? (parked | (park_sel & {CPU_PAIR_COUNT{park_edge}})) : '0;
	wire next_cpu_stopped = |next_parked;

	// ****************************************
	// cpu pair pins
	// ****************************************
	// parked complement is undriven; its register rests low behind oe_n
	ocs_cpu_pin_s pin [CPU_PAIR_COUNT];
	always_comb begin
		for (int i = 0; i < CPU_PAIR_COUNT; i++) begin
			pin[i].cpu_pair_true_leg       = next_parked[i] | ~phase;
			pin[i].cpu_pair_complement_leg = ~next_parked[i] & phase;
			pin[i].complement_oe_n         = next_parked[i];
			pin[i].true_boost              = drive_current_multiplier_select;
		end
	end

	// ****************************************
	// cpu output registers
	// ****************************************
	// every pin leaves a flop, so a park never cuts a pulse short
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			parked                  <= CPU_RESET;
			cpu_pair_true_leg       <= CPU_RESET;
			cpu_pair_complement_leg <= CPU_RESET;
			cpu_complement_oe_n     <= CPU_RESET;
			cpu_true_boost          <= CPU_RESET;
			cpu_stopped             <= 1'b0;
		end else begin
			parked      <= next_parked;
			cpu_stopped <= next_cpu_stopped;
			for (int i = 0; i < CPU_PAIR_COUNT; i++) begin
				cpu_pair_true_leg[i]       <= pin[i].cpu_pair_true_leg;
				cpu_pair_complement_leg[i] <= pin[i].cpu_pair_complement_leg;
				cpu_complement_oe_n[i]     <= pin[i].complement_oe_n;
				cpu_true_boost[i]          <= pin[i].true_boost;
			end
		end
	end

endmodule

// ### testbench/ocs_chipset_model.sv
`timescale 1ns/100ps
module ocs_chipset_model (
	input  wire logic       ref_clk,
	input  wire logic [2:0] stop_cmd,
	output logic            pci_stop_request_n = 1,
	output logic            cpu_stop_request_n = 1,
	output logic            power_down_request_n = 1
);
	// pins move just after a rise, leaving most of a period of setup
	always @(posedge ref_clk)
		{power_down_request_n, cpu_stop_request_n, pci_stop_request_n} <= ~stop_cmd;
endmodule

// ### testbench/ocs_stop_ctrl_asserts.sv
`timescale 1ns/100ps
module ocs_stop_ctrl_asserts
	import ocs_pkg::*;
(
	input wire logic       ref_clk, rst, pci_stop_request_n, cpu_stop_request_n,
	input wire logic       power_down_request_n, drive_current_multiplier_select,
	input wire logic [2:0] free_stoppable, cpu_stoppable, free_running_pci_clock_out,
	input wire logic [2:0] cpu_pair_true_leg, cpu_pair_complement_leg,
	input wire logic [2:0] cpu_complement_oe_n, cpu_true_boost,
	input wire logic [6:0] pci_bus_clock_out,
	input wire logic       cpu_stopped
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// counters of consecutive low samples, saturating
	logic [3:0] pci_cnt, cpu_cnt;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pci_cnt <= 4'h0;
			cpu_cnt <= 4'h0;
		end else begin
			pci_cnt <= pci_stop_request_n ? 4'h0 : pci_cnt + {3'h0, pci_cnt != 4'hf};
			cpu_cnt <= (cpu_stop_request_n | ~power_down_request_n) ? 4'h0 :
				cpu_cnt + {3'h0, cpu_cnt != 4'hf};
		end
	end
	sequence cpu_fall; $fell(cpu_stop_request_n) && !cpu_stopped; endsequence
	sequence mult_steady; $stable(drive_current_multiplier_select)[*2]; endsequence
	a_pci_held_low: assert property (pci_cnt >= 4'h8 |-> pci_bus_clock_out == 7'h00)
		else $error("pci clock running while stopped");
	a_free_held_low: assert property (pci_cnt >= 4'h8 |->
		(free_running_pci_clock_out & free_stoppable) == 3'h0)
		else $error("stoppable free clock running");
	a_cpu_not_early: assert property (cpu_fall |-> !cpu_stopped[*5])
		else $error("cpu parked before sampling");
	a_cpu_parked: assert property (cpu_cnt >= 4'hc |-> (cpu_pair_true_leg & cpu_stoppable)
		== cpu_stoppable && (cpu_pair_complement_leg & cpu_stoppable) == 3'h0)
		else $error("stoppable pair not parked");
	a_float_low: assert property ((cpu_complement_oe_n & (cpu_pair_complement_leg |
		~cpu_pair_true_leg)) == 3'h0)
		else $error("floating pair not at rest level");
	a_boost_kept: assert property (mult_steady |->
		cpu_true_boost == {3{drive_current_multiplier_select}})
		else $error("drive boost differs from select");
	a_pci_full_high: assert property ($rose(pci_bus_clock_out[0]) |=>
		$fell(pci_bus_clock_out[0]))
		else $error("pci high phase wrong length");
	a_pci_equal: assert property (pci_bus_clock_out == {7{pci_bus_clock_out[0]}})
		else $error("pci outputs differ");
endmodule
bind ocs_stop_ctrl ocs_stop_ctrl_asserts i_ocs_stop_ctrl_asserts (.*);

// ### testbench/ocs_stop_ctrl_tb.sv
`timescale 1ns/100ps
module ocs_stop_ctrl_tb
	import ocs_pkg::*;
;
	logic       ref_clk = 0, rst = 1, drive_current_multiplier_select = 1, x;
	logic [2:0] stop_cmd = 0, free_stoppable = 3'h5, cpu_stoppable = 3'h3;
	logic       pci_stop_request_n, cpu_stop_request_n, power_down_request_n, cpu_stopped;
	logic [6:0] pci_bus_clock_out;
	logic [2:0] free_running_pci_clock_out, cpu_pair_true_leg, cpu_pair_complement_leg;
	logic [2:0] cpu_complement_oe_n, cpu_true_boost;
	int         err_count = 0, total_checks = 0;
	ocs_chipset_model i_ocs_chipset_model (.*);
	ocs_stop_ctrl     i_ocs_stop_ctrl (.*);
	initial forever #25 ref_clk = ~ref_clk;
	task chk(input logic [6:0] seen, input logic [6:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("checks=%0d mismatches=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task cmd(input logic [2:0] c);
		@(posedge ref_clk) stop_cmd <= c;
	endtask
	task wait_stop(input logic v);
		int i;
		for (i = 0; i < 40 && cpu_stopped !== v; i++) cyc(1);
		if (i == 40) begin
			err_count++;
			test_done();
		end
	endtask
	task t_pci;
		cmd(3'h1);
		cyc(9);
		x = free_running_pci_clock_out[1];
		chk(pci_bus_clock_out, 7'h00);
		chk(free_running_pci_clock_out & 3'h5, 7'h00);
		cyc(1);
		chk(pci_bus_clock_out, 7'h00);
		chk(free_running_pci_clock_out[1], {6'h0, ~x});
		cmd(3'h0);
		cyc(9);
		x = pci_bus_clock_out[0];
		cyc(1);
		chk(pci_bus_clock_out[0], {6'h0, ~x});
	endtask
	task t_cpu;
		cmd(3'h2);
		cyc(5);
		chk(cpu_stopped, 1'b0);
		wait_stop(1'b1);
		cyc(2);
		x = cpu_pair_true_leg[2];
		chk(cpu_pair_true_leg & 3'h3, 7'h03);
		chk(cpu_pair_complement_leg & 3'h3, 7'h00);
		chk(cpu_complement_oe_n & 3'h3, 7'h03);
		chk(cpu_true_boost, 7'h07);
		cyc(1);
		chk(cpu_pair_true_leg[2], {6'h0, ~x});
		cmd(3'h0);
		wait_stop(1'b0);
		cyc(2);
		chk(cpu_complement_oe_n, 7'h00);
	endtask
	task t_pd;
		cmd(3'h4);
		wait_stop(1'b1);
		cyc(3);
		chk(pci_bus_clock_out, 7'h00);
		chk(free_running_pci_clock_out, 7'h00);
		chk(cpu_pair_true_leg, 7'h07);
		chk(cpu_true_boost, 7'h07);
		@(posedge ref_clk) drive_current_multiplier_select <= 1'b0;
		cyc(2);
		chk(cpu_true_boost, 7'h00);
		chk(cpu_complement_oe_n, 7'h07);
		cmd(3'h0);
		wait_stop(1'b0);
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 0;
		cyc(3);
		t_pci();
		t_cpu();
		t_pd();
		test_done();
	end
endmodule
